/* File: cfs_top.sv */
/*
 * Charger fault supervisor: thermistor, die temperature and defective
 * battery handling, with APB registers.
 * Assumes asynchronous comparator levels and a charger FSM that obeys
 * the suspend, terminate, restart and trickle-force outputs.
 */
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module cfs_top
  import cfs_pkg::*;
#(
  parameter bit ROM_CONFIG = 1'b0,
  parameter longint CYC_PER_MIN = CFS_CYC_PER_MIN
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] cond_async,
  input wire logic charging,
  input wire logic trickle_mode,
  input wire logic fast_charge_select,
  input wire logic power_reapplied,
  input wire logic usb_suspend,
  output logic charge_suspend,
  output logic charge_terminate,
  output logic force_trickle,
  output logic restart_charger,
  output logic charger_summary_irq
);

  cfs_cond_t cond, cond_d;
  cfs_state_t state;
  logic [15:0] ctrl_one;
  logic [3:0] charge_timeout_setting;
  logic [CFS_NFLAGS-1:0] flags, ev;
  logic [31:0] min_cnt;
  logic [9:0] trk_min, quarter_min, check_min;
  logic trickle_pause_en, unlocked, checked, check_now, clr_fail;
  logic wr, rd, hot_act, cold_act, ntc_act;

  // Assertion clock and reset
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Input synchronisation
  // ****************************************
  cfs_sync #(.WIDTH(6)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(cond_async),
    .q(cond)
  );

  // Previous sample for edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cond_d <= '0;
    end else begin
      cond_d <= cond;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;

  // One wait state: ready in second access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Security key register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else if (wr && paddr == CFS_KEY_OFS) begin
      unlocked <= (pwdata[15:0] == CFS_KEY_VALUE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_one <= CFS_CTRL_ONE_RST;
    end else if (wr && paddr == CFS_CTRL_ONE_OFS && unlocked && !ROM_CONFIG) begin
      ctrl_one[CFS_NTC_BIT] <= pwdata[CFS_NTC_BIT];
      ctrl_one[CFS_HOT_BIT] <= pwdata[CFS_HOT_BIT];
      ctrl_one[CFS_COLD_BIT] <= pwdata[CFS_COLD_BIT];
    end
  end

  // Timeout and trickle pause option
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      charge_timeout_setting <= CFS_TIME_RST;
      trickle_pause_en <= 1'b1;
    end else if (wr && paddr == CFS_CTRL_TWO_OFS && unlocked) begin
      charge_timeout_setting <= pwdata[CFS_TIME_LSB +: 4];
      trickle_pause_en <= pwdata[CFS_TRK_PAUSE_BIT];
    end
  end

  // Read data mux, registered at access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= 1'b0;
      unique case (paddr)
        CFS_CTRL_ONE_OFS: prdata <= {16'h0000, ctrl_one};
        CFS_CTRL_TWO_OFS: prdata <= {20'h00000, charge_timeout_setting,
                                     7'h00, trickle_pause_en};
        CFS_FLAGS_OFS: prdata <= {26'h0000000, flags};
        CFS_STATUS_OFS: prdata <= {22'h000000, state, cond};
        CFS_KEY_OFS: prdata <= {31'h00000000, unlocked};
        default: begin
          prdata <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Qualified conditions
  // ****************************************
  // disabled monitors are ignored
  assign hot_act = cond.hot && ctrl_one[CFS_HOT_BIT];
  assign cold_act = cond.cold && ctrl_one[CFS_COLD_BIT];
  assign ntc_act = cond.ntc_missing && ctrl_one[CFS_NTC_BIT];

  assign ev[CFS_F_COLD] = cold_act && !cond_d.cold;
  assign ev[CFS_F_HOT] = hot_act && !cond_d.hot;
  assign ev[CFS_F_WARN] = cond.die_warn && !cond_d.die_warn;
  assign ev[CFS_F_SHDN] = cond.die_shdn && !cond_d.die_shdn;
  assign ev[CFS_F_NTC] = ntc_act && !cond_d.ntc_missing;
  assign ev[CFS_F_FAIL] = check_now && cond.battery_supply_pin_low;

  // sticky flags, read clears, set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags <= '0;
    end else if (rd && paddr == CFS_FLAGS_OFS) begin
      flags <= (flags & ~prdata[CFS_NFLAGS-1:0]) | ev; // Drop reported bits only
    end else begin
      flags <= flags | ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      charger_summary_irq <= 1'b0;
    end else begin
      charger_summary_irq <= |(flags | ev);
    end
  end

  // ****************************************
  // Trickle defective-battery check timer
  // ****************************************
  // timeout minutes over four
  assign quarter_min = 10'((CFS_TIMEOUT_BASE_MIN +
                      CFS_TIMEOUT_STEP_MIN * charge_timeout_setting) / 4);
  assign check_min = (quarter_min > 10'(CFS_MIN_CHECK_MIN)) ?
                     quarter_min : 10'(CFS_MIN_CHECK_MIN);
  assign check_now = (state == CFS_CHARGE) && trickle_mode && !checked &&
                     (trk_min >= check_min);

  // Minute counter, runs only while trickle charging unsuspended
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state != CFS_CHARGE || !trickle_mode || !charging) begin
      min_cnt <= '0;
      if (!rst_n || state != CFS_CHARGE || !charging) begin
        trk_min <= '0;
        checked <= 1'b0;
      end
    end else if (check_now) begin
      checked <= 1'b1;
    end else if (!charge_suspend && !checked) begin
      if (min_cnt == 32'(CYC_PER_MIN - 1)) begin
        min_cnt <= '0;
        trk_min <= trk_min + 10'd1;
      end else begin
        min_cnt <= min_cnt + 32'd1;
      end
    end
  end

  // ****************************************
  // Fault state machine
  // ****************************************
  // fail clear causes
  assign clr_fail = !cond.battery_supply_pin_low || power_reapplied || usb_suspend;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= CFS_IDLE;
    // die shutdown wins from any state
    end else if (cond.die_shdn) begin
      state <= CFS_SHUTOFF;
    end else begin
      unique case (state)
        CFS_IDLE: begin
          if (charging) begin
            state <= CFS_CHARGE;
          end
        end
        CFS_CHARGE: begin
          if (check_now && cond.battery_supply_pin_low) begin
            state <= CFS_FAILED;
          end else if (!charging) begin
            state <= CFS_IDLE;
          end
        end
        CFS_FAILED: begin
          if (clr_fail) begin
            state <= CFS_IDLE;
          end
        end
        CFS_SHUTOFF: begin
          if (power_reapplied) begin
            state <= CFS_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Charger control outputs
  // ****************************************
  // suspend while condition holds
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      charge_suspend <= 1'b0;
    end else begin
      charge_suspend <= hot_act || cold_act || ntc_act ||
                        (cond.die_warn && (!trickle_mode || trickle_pause_en));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      charge_terminate <= 1'b0;
      restart_charger <= 1'b0;
    end else begin
      charge_terminate <= cond.die_shdn || state == CFS_FAILED ||
                          state == CFS_SHUTOFF;
      restart_charger <= state == CFS_FAILED && clr_fail && !cond.die_shdn;
    end
  end

  // fast with low battery falls back
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      force_trickle <= 1'b0;
    end else begin
      force_trickle <= fast_charge_select && cond.battery_supply_pin_low;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_shdn_term: assert property (cond.die_shdn |=> charge_terminate)
    else $error("shutdown did not terminate");
  chk_hot_susp: assert property (hot_act |=> charge_suspend)
    else $error("hot did not suspend");
  chk_hot_ignore: assert property (
    (!ctrl_one[CFS_HOT_BIT] && !cond.cold && !cond.ntc_missing &&
     !cond.die_warn) |=> !charge_suspend)
    else $error("disabled monitor suspended");
  chk_flag_set: assert property (ev[CFS_F_COLD] |=> flags[CFS_F_COLD])
    else $error("cold flag lost");
  chk_flag_rdclr: assert property (
    (rd && paddr == CFS_FLAGS_OFS && ev == '0) |=>
      (flags & prdata[CFS_NFLAGS-1:0]) == '0)
    else $error("flags not cleared by read");
  chk_irq_or: assert property ((flags != '0) |=> charger_summary_irq)
    else $error("irq not asserted");
  chk_key_lock: assert property (
    (wr && paddr == CFS_CTRL_ONE_OFS && !unlocked) |=> $stable(ctrl_one))
    else $error("locked write took effect");
  chk_fail_go: assert property (
    (check_now && cond.battery_supply_pin_low && !cond.die_shdn) |=>
      state == CFS_FAILED ##1 charge_terminate)
    else $error("defective battery not handled");
  chk_fail_clr: assert property (
    (state == CFS_FAILED && clr_fail && !cond.die_shdn) |=> state == CFS_IDLE)
    else $error("fail not cleared");
  chk_fast_fb: assert property (
    (fast_charge_select && cond.battery_supply_pin_low) |=> force_trickle)
    else $error("no trickle fallback");
  cov_fail: cover property (@(posedge clk_sys) state == CFS_FAILED);
  cov_shdn: cover property (@(posedge clk_sys) state == CFS_SHUTOFF);
  cov_susp: cover property (@(posedge clk_sys) $fell(charge_suspend));

endmodule

/* File: cfs_pkg.sv */
/*
 * Shared constants and types for the charger fault supervisor.
 * Assumes a 25 MHz system clock and an APB register bus.
 */
package cfs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CFS_CTRL_ONE_OFS = 8'hA8;   // charger_control_one
  localparam logic [7:0] CFS_CTRL_TWO_OFS = 8'hAC;   // timeout and options
  localparam logic [7:0] CFS_FLAGS_OFS = 8'hB0;      // fault flags, read clears
  localparam logic [7:0] CFS_STATUS_OFS = 8'hB4;     // live state
  localparam logic [7:0] CFS_KEY_OFS = 8'hB8;        // security key

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFS_NTC_BIT = 3;
  localparam int CFS_HOT_BIT = 2;
  localparam int CFS_COLD_BIT = 1;
  localparam logic [15:0] CFS_CTRL_ONE_RST = 16'h000E;
  localparam int CFS_TIME_LSB = 8;
  localparam logic [3:0] CFS_TIME_RST = 4'hB;
  localparam int CFS_TRK_PAUSE_BIT = 0;
  localparam logic [15:0] CFS_KEY_VALUE = 16'h0097;  // unlock pattern

  // Flag bit positions in the flag register
  localparam int CFS_F_COLD = 0;
  localparam int CFS_F_HOT = 1;
  localparam int CFS_F_FAIL = 2;
  localparam int CFS_F_WARN = 3;
  localparam int CFS_F_SHDN = 4;
  localparam int CFS_F_NTC = 5;
  localparam int CFS_NFLAGS = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CFS_CLK_HZ = 25_000_000;
  localparam int CFS_MIN_CHECK_MIN = 30;    // minutes
  localparam int CFS_TIMEOUT_BASE_MIN = 60; // minutes at code zero
  localparam int CFS_TIMEOUT_STEP_MIN = 30; // minutes per code step
  localparam longint CFS_CYC_PER_MIN = longint'(CFS_CLK_HZ) * 60;

  // Fault conditions from the comparators
  typedef struct packed {
    logic ntc_missing;
    logic die_shdn;
    logic die_warn;
    logic battery_supply_pin_low;
    logic hot;
    logic cold;
  } cfs_cond_t;

  typedef enum logic [3:0] {
    CFS_IDLE    = 4'b0001,
    CFS_CHARGE  = 4'b0010,
    CFS_FAILED  = 4'b0100,
    CFS_SHUTOFF = 4'b1000
  } cfs_state_t;

endpackage

/* File: cfs_sync.sv */
/*
 * Two-flop synchroniser, one per bit, for comparator inputs.
 * Assumes inputs are asynchronous levels.
 */
`timescale 1ns/1ns
module cfs_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // ****************************************
  // Per-bit two-stage sampling
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

/* File: cfs_charger_model.sv */
/*
 * Far-side model: battery and die comparators plus the charger state
 * logic that obeys the supervisor's suspend and terminate outputs.
 * Assumes the bench commands condition levels and charge requests.
 */
`timescale 1ns/1ns
module cfs_charger_model
  import cfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast_req,
  input wire cfs_cond_t cond_req,
  input wire logic charge_suspend,
  input wire logic charge_terminate,
  input wire logic force_trickle,
  input wire logic restart_charger,
  output logic [5:0] cond_async,
  output logic charging,
  output logic trickle_mode,
  output logic fast_charge_select
);
  logic stopped;

  // Charge stays off after a terminate until restarted or dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n || restart_charger || !run) begin
      stopped <= 1'b0;
    end else if (charge_terminate) begin
      stopped <= 1'b1;
    end
  end

  // Comparator levels pass straight through; mode follows the request unless force_trickle forces trickle
  assign cond_async = cond_req;
  assign charging = run && !stopped && !charge_suspend;
  assign trickle_mode = !(fast_req && !force_trickle);
  assign fast_charge_select = fast_req;
endmodule

/* File: testbench.sv */
/*
 * Self-checking bench for the charger fault supervisor.
 * Assumes the APB timing and register map of the design package.
 */
`timescale 1ns/1ns
module testbench
  import cfs_pkg::*;
;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic run, fast_req, power_reapplied, usb_suspend;
  logic [5:0] cond_async;
  logic charging, trickle_mode, fast_charge_select, charge_suspend;
  logic charge_terminate, force_trickle, restart_charger;
  logic charger_summary_irq;
  cfs_cond_t cond;
  logic [32:0] expq[$];
  int n_errors, checks_done, cycles, n_restart, m;

  cfs_top #(.ROM_CONFIG(1'b0), .CYC_PER_MIN(4)) u_cfs_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond_async(cond_async),
    .charging(charging), .trickle_mode(trickle_mode),
    .fast_charge_select(fast_charge_select),
    .power_reapplied(power_reapplied), .usb_suspend(usb_suspend),
    .charge_suspend(charge_suspend), .charge_terminate(charge_terminate),
    .force_trickle(force_trickle), .restart_charger(restart_charger),
    .charger_summary_irq(charger_summary_irq));

  cfs_charger_model u_cfs_charger_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .run(run), .fast_req(fast_req),
    .cond_req(cond), .charge_suspend(charge_suspend),
    .charge_terminate(charge_terminate), .force_trickle(force_trickle),
    .restart_charger(restart_charger), .cond_async(cond_async),
    .charging(charging), .trickle_mode(trickle_mode),
    .fast_charge_select(fast_charge_select));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task ck1(input string nm, input logic e, input logic g);
    chk(nm, {32'h0, e}, {32'h0, g});
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task do_reset();
    rst_n <= 1'b0;
    wt(6);
    rst_n <= 1'b1;
    wt(1);
  endtask

  // ****************************************
  // Clock, read watcher and timeout
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Tests need about 900 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0 && expq.size() > 0) begin
      chk("read", expq.pop_front(), {pslverr, prdata});
    end
    if (restart_charger === 1'b1) n_restart++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h52;
    {psel, penable, pwrite, run, fast_req} = '0;
    {power_reapplied, usb_suspend, paddr, pwdata} = '0;
    cond = '0;
    do_reset();
    rd(CFS_CTRL_ONE_OFS, {17'h0, CFS_CTRL_ONE_RST});
    rd(CFS_CTRL_TWO_OFS, {21'h0, CFS_TIME_RST, 8'h01});
    rd(CFS_FLAGS_OFS, 33'h0);
    rd(8'hC0, 33'h100000000);
    // Locked writes, unlock, random relock
    apb(1'b1, CFS_CTRL_ONE_OFS, 32'h0);
    rd(CFS_CTRL_ONE_OFS, 33'h00E);
    apb(1'b1, CFS_KEY_OFS, {16'h0, CFS_KEY_VALUE});
    rd(CFS_KEY_OFS, 33'h1);
    r = xs();
    apb(1'b1, CFS_KEY_OFS, {16'h0, r[15:0] | 16'h0100});
    rd(CFS_KEY_OFS, 33'h0);
    apb(1'b1, CFS_KEY_OFS, {16'h0, CFS_KEY_VALUE});
    apb(1'b1, CFS_CTRL_ONE_OFS, 32'h0);
    rd(CFS_CTRL_ONE_OFS, 33'h0);
    // Disabled monitors: cold, hot, thermistor missing
    for (int b = 0; b < 6; b += (b == 1) ? 4 : 1) begin
      cond <= cfs_cond_t'(6'h01 << b);
      wt(5);
      ck1("charge_suspend", 1'b0, charge_suspend);
      rd(CFS_FLAGS_OFS, 33'h0);
      cond <= '0;
      wt(5);
    end
    apb(1'b1, CFS_CTRL_ONE_OFS, 32'h0000000E);
    // Enabled monitors raise flag, suspend, irq
    for (int b = 0; b < 6; b += (b == 1) ? 4 : 1) begin
      cond <= cfs_cond_t'(6'h01 << b);
      wt(5);
      ck1("charge_suspend", 1'b1, charge_suspend);
      ck1("irq", 1'b1, charger_summary_irq);
      rd(CFS_FLAGS_OFS, {1'b0, 32'h1 << b});
      wt(2);
      ck1("irq", 1'b0, charger_summary_irq);
      cond <= '0;
      wt(5);
      ck1("charge_suspend", 1'b0, charge_suspend);
    end
    // Die warning with trickle pause option on and off
    cond <= 6'h08;
    wt(5);
    ck1("charge_suspend", 1'b1, charge_suspend);
    rd(CFS_FLAGS_OFS, 33'h8);
    apb(1'b1, CFS_CTRL_TWO_OFS, {20'h0, CFS_TIME_RST, 8'h00});
    wt(2);
    ck1("charge_suspend", 1'b0, charge_suspend);
    fast_req <= 1'b1;
    wt(3);
    ck1("charge_suspend", 1'b1, charge_suspend);
    fast_req <= 1'b0;
    cond <= 6'h00;
    wt(5);
    ck1("charge_suspend", 1'b0, charge_suspend);
    // Fast select with low battery
    fast_req <= 1'b1;
    cond <= 6'h04;
    wt(5);
    ck1("force_trickle", 1'b1, force_trickle);
    fast_req <= 1'b0;
    wt(2);
    ck1("force_trickle", 1'b0, force_trickle);
    // Die shutdown, left only by power reapplied
    cond <= 6'h10;
    wt(5);
    ck1("charge_terminate", 1'b1, charge_terminate);
    rd(CFS_FLAGS_OFS, 33'h10);
    cond <= 6'h00;
    wt(5);
    ck1("charge_terminate", 1'b1, charge_terminate);
    power_reapplied <= 1'b1;
    wt(1);
    power_reapplied <= 1'b0;
    wt(3);
    ck1("charge_terminate", 1'b0, charge_terminate);
    // Code 0: check falls at 30 minutes, 120 cycles
    apb(1'b1, CFS_CTRL_TWO_OFS, 32'h00000001);
    cond <= 6'h04;
    wt(5);
    run <= 1'b1;
    wt(110);
    ck1("charge_terminate", 1'b0, charge_terminate);
    wt(25);
    ck1("charge_terminate", 1'b1, charge_terminate);
    rd(CFS_FLAGS_OFS, 33'h4);
    m = n_restart;
    cond <= 6'h00;
    wt(5);
    ck1("charge_terminate", 1'b0, charge_terminate);
    chk("restart_count", 33'h1, 33'(n_restart - m));
    // Code 15: check at 127 minutes, 508 cycles
    run <= 1'b0;
    do_reset();
    apb(1'b1, CFS_KEY_OFS, {16'h0, CFS_KEY_VALUE});
    apb(1'b1, CFS_CTRL_TWO_OFS, 32'h00000F01);
    cond <= 6'h04;
    wt(5);
    run <= 1'b1;
    wt(400);
    ck1("charge_terminate", 1'b0, charge_terminate);
    wt(130);
    ck1("charge_terminate", 1'b1, charge_terminate);
    m = n_restart;
    usb_suspend <= 1'b1;
    wt(4);
    ck1("charge_terminate", 1'b0, charge_terminate);
    chk("restart_count", 33'h1, 33'(n_restart - m));
    usb_suspend <= 1'b0;
    wt(2);
    wrap_up();
  end
endmodule
